// [src/fts_fan_ctrl.sv]
// Purpose: fan tach measurement, PWM/DC drive and automatic regulation
// Assumes: temperatures arrive on hclk, tach pins are asynchronous
// Notes: one tach period is taken as one revolution
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/100ps
module fts_fan_ctrl import fts_pkg::*; #(
  parameter int TICK_CYC = TACH_TICK_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Temperature readings
  input wire logic [7:0] system_temp_input,
  input wire logic [7:0] processor_temp_input,
  input wire logic [7:0] auxiliary_temp_input,
  // Fan pins: 0 system, 1 processor a, 2 auxiliary, 3 processor b
  input wire logic [3:0] tach_in,
  output logic [3:0] fan_pwm,
  output logic [3:0][5:0] fan_dc_level,
  output logic [3:0] fan_warning
);
  logic [7:0] val [4];
  logic [7:0] frq [4];
  logic [7:0] tgt [4];
  logic [7:0] tol [4];
  logic [7:0] strt [4];
  logic [7:0] stpv [4];
  logic [7:0] stpt [4];
  logic [7:0] cnt [4];
  fts_cfg_s cfg [4];
  logic [7:0] tsrc_a;
  logic [7:0] tsrc_b;
  logic [12:0] tick_div;
  logic base_tick;
  logic [7:0] step_div;
  logic step_en;
  logic [3:0] tach_s1;
  logic [3:0] tach_s2;
  logic [3:0] tach_s3;
  logic wr_pend;
  logic [7:0] wr_idx;
  logic [7:0] rd_val;
  logic acc;
  logic [7:0] a_idx;

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_div <= 13'h0;
      base_tick <= 1'b0;
    end else begin
      base_tick <= (tick_div == 13'(TICK_CYC - 1));
      if (tick_div == 13'(TICK_CYC - 1)) begin
        tick_div <= 13'h0;
      end else begin
        tick_div <= tick_div + 13'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_div <= 8'h0;
      step_en <= 1'b0;
    end else begin
      step_en <= base_tick && (step_div == 8'(STEP_TICKS - 1));
      if (base_tick) begin
        step_div <= (step_div == 8'(STEP_TICKS - 1)) ? 8'h0 : step_div + 8'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tach_s1 <= 4'h0;
      tach_s2 <= 4'h0;
      tach_s3 <= 4'h0;
    end else begin
      tach_s1 <= tach_in;
      tach_s2 <= tach_s1;
      tach_s3 <= tach_s2;
    end
  end

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  assign acc = hsel && hready && htrans[1];
  assign a_idx = haddr[9:2];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx <= 8'h0;
    end else begin
      wr_pend <= acc && hwrite && (haddr[31:10] == 22'h0);
      if (acc) begin
        wr_idx <= a_idx;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tsrc_a <= TSRC_RST;
      tsrc_b <= TSRC_RST;
    end else if (wr_pend) begin
      if (wr_idx == IDX_TSRC_A) begin
        tsrc_a <= hwdata[7:0];
      end
      if (wr_idx == IDX_TSRC_B) begin
        tsrc_b <= hwdata[7:0];
      end
    end
  end

  always_comb begin
    rd_val = 8'h00;
    if (a_idx == IDX_SYS_TEMP) begin
      rd_val = system_temp_input;
    end
    if (a_idx == IDX_TSRC_A) begin
      rd_val = tsrc_a;
    end
    if (a_idx == IDX_TSRC_B) begin
      rd_val = tsrc_b;
    end
    for (int i = 0; i < 4; i++) begin
      if (a_idx == VAL_IDX[i]) begin
        rd_val = val[i];
      end
      if (a_idx == FRQ_IDX[i]) begin
        rd_val = frq[i];
      end
      if (a_idx[7:5] == BANK_TOP && a_idx[4:3] == 2'(i)) begin
        case (a_idx[2:0])
          K_CFG: rd_val = {1'b0, cfg[i]};
          K_TGT: rd_val = tgt[i];
          K_TOL: rd_val = tol[i];
          K_STRT: rd_val = strt[i];
          K_STPV: rd_val = stpv[i];
          K_STPT: rd_val = stpt[i];
          K_CNT: rd_val = cnt[i];
          default: rd_val = {7'h0, fan_warning[i]};
        endcase
      end
    end
    if (haddr[31:10] != 22'h0) begin
      rd_val = 8'h00;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= (acc && !hwrite) ? {24'h0, rd_val} : 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------
  // Per-fan logic
  // ----------------------------------------
  for (genvar g = 0; g < 4; g++) begin : g_fan
    logic wbank;
    logic [6:0] pre;
    logic [6:0] mask;
    logic [7:0] run;
    logic [7:0] pdiv;
    logic [7:0] pcnt;
    logic [7:0] stop_cnt;
    logic [2:0] src;
    logic [7:0] temp;
    logic [8:0] hi_end;
    logic above_hi;
    logic above_lo;
    logic below_lo;
    logic cnt_hi;
    logic cnt_lo;
    logic [7:0] floor_v;
    logic warn_set;
    logic warn_clr;

    assign wbank = wr_pend && wr_idx[7:5] == BANK_TOP && wr_idx[4:3] == 2'(g);

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cfg[g] <= '{div: DIV_RST, stop_en: 1'b0, mode: FTS_MANUAL, dc: 1'b0};
        tgt[g] <= 8'h0;
        tol[g] <= 8'h0;
        strt[g] <= 8'h0;
        stpv[g] <= 8'h0;
        stpt[g] <= 8'h0;
        frq[g] <= FRQ_RST;
      end else begin
        if (wbank && wr_idx[2:0] == K_CFG) begin
          cfg[g] <= fts_cfg_s'(hwdata[6:0]);
        end
        if (wbank && wr_idx[2:0] == K_TGT) begin
          tgt[g] <= hwdata[7:0];
        end
        if (wbank && wr_idx[2:0] == K_TOL) begin
          tol[g] <= hwdata[7:0];
        end
        if (wbank && wr_idx[2:0] == K_STRT) begin
          strt[g] <= hwdata[7:0];
        end
        if (wbank && wr_idx[2:0] == K_STPV) begin
          stpv[g] <= hwdata[7:0];
        end
        if (wbank && wr_idx[2:0] == K_STPT) begin
          stpt[g] <= hwdata[7:0];
        end
        if (wr_pend && wr_idx == FRQ_IDX[g]) begin
          frq[g] <= hwdata[7:0];
        end
      end
    end

    // Tach period counter, prescaled by two to the divisor code
    assign mask = 7'((8'h1 << cfg[g].div) - 8'h1);

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        pre <= 7'h0;
        run <= 8'h0;
        cnt[g] <= CNT_MAX;
      end else if (tach_s2[g] && !tach_s3[g]) begin
        cnt[g] <= run;
        run <= 8'h0;
        pre <= 7'h0;
      end else if (base_tick) begin
        pre <= ((pre & mask) == mask) ? 7'h0 : pre + 7'h1;
        if ((pre & mask) == mask && run != CNT_MAX) begin
          run <= run + 8'h1;
        end
        if (run == CNT_MAX) begin
          cnt[g] <= CNT_MAX;
        end
      end
    end

    // PWM of 255 steps, step rate set by the frequency register
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        pdiv <= 8'h0;
        pcnt <= 8'h0;
        fan_pwm[g] <= 1'b0;
        fan_dc_level[g] <= 6'h0;
      end else begin
        if (pdiv >= frq[g]) begin
          pdiv <= 8'h0;
          pcnt <= (pcnt >= PWM_LAST) ? 8'h0 : pcnt + 8'h1;
        end else begin
          pdiv <= pdiv + 8'h1;
        end
        fan_pwm[g] <= !cfg[g].dc && (pcnt < val[g] || val[g] == 8'hff);
        fan_dc_level[g] <= cfg[g].dc ? val[g][7:2] : 6'h0;
      end
    end

    // Temperature source
    always_comb begin
      src = 3'h0;
      if (g == 1) begin
        src = tsrc_a[2:0];
      end else if (g == 2) begin
        src = tsrc_a[6:4];
      end else if (g == 3) begin
        src = tsrc_b[7:5];
      end
      case (src)
        SRC_PROC: temp = processor_temp_input;
        SRC_AUX: temp = auxiliary_temp_input;
        default: temp = system_temp_input;
      endcase
    end

    assign hi_end = {1'b0, tgt[g]} + {1'b0, tol[g]};
    assign above_hi = {1'b0, temp} > hi_end;
    assign above_lo = ({1'b0, temp} + {1'b0, tol[g]}) > {1'b0, tgt[g]};
    assign below_lo = ({1'b0, temp} + {1'b0, tol[g]}) < {1'b0, tgt[g]};
    assign cnt_hi = {1'b0, cnt[g]} > hi_end;
    assign cnt_lo = ({1'b0, cnt[g]} + {1'b0, tol[g]}) < {1'b0, tgt[g]};
    assign floor_v = cfg[g].stop_en ? stpv[g] : 8'h0;
    assign warn_set = step_en && cfg[g].mode == FTS_TEMP && above_hi && val[g] == 8'hff;
    assign warn_clr = wbank && wr_idx[2:0] == K_STAT && hwdata[0];

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        fan_warning[g] <= 1'b0;
      end else begin
        fan_warning[g] <= warn_set || (fan_warning[g] && !warn_clr);
      end
    end

    // Output value: software write, else one regulation step
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        val[g] <= VAL_RST;
        stop_cnt <= 8'h0;
      end else if (wr_pend && wr_idx == VAL_IDX[g]) begin
        val[g] <= hwdata[7:0];
        stop_cnt <= 8'h0;
      end else if (step_en) begin
        case (cfg[g].mode)
          FTS_TEMP: begin
            if (above_lo && val[g] == 8'h0) begin
              val[g] <= strt[g];
              stop_cnt <= 8'h0;
            end else if (above_hi) begin
              stop_cnt <= 8'h0;
              if (val[g] != 8'hff) begin
                val[g] <= val[g] + 8'h1;
              end
            end else if (below_lo && val[g] != 8'h0) begin
              if (val[g] > floor_v) begin
                val[g] <= val[g] - 8'h1;
                stop_cnt <= 8'h0;
              end else if (stop_cnt >= stpt[g]) begin
                val[g] <= 8'h0;
                stop_cnt <= 8'h0;
              end else begin
                stop_cnt <= stop_cnt + 8'h1;
              end
            end else begin
              stop_cnt <= 8'h0;
            end
          end
          FTS_COUNT: begin
            if (cnt_hi && val[g] != 8'hff) begin
              val[g] <= val[g] + 8'h1;
            end else if (cnt_lo && val[g] != 8'h0) begin
              val[g] <= val[g] - 8'h1;
            end
          end
          default: begin
            stop_cnt <= 8'h0;
          end
        endcase
      end
    end
  end

endmodule : fts_fan_ctrl

// [src/fts_pkg.sv]
// Purpose: constants and types of the fan tach and speed control block
// Assumes: one 100 MHz clock, AHB-Lite register access
// Notes: byte address of a register is four times its index
//
// Contract
// - tach count gives rpm with divisor
// - three-bit divisor code selects power of two
// - divisor resets to two
// - four outputs, each PWM or DC
// - PWM duty is value over 255
// - PWM value resets to all ones
// - each output has own PWM frequency
// - DC level is upper six bits over 64
// - DC value resets ones, low bits reserved
// - automatic modes start from current value
// - off below low end, then start-up value
// - above high end, step output up
// - full output still hot raises warning
// - inside range, hold output
// - below low end, step to zero or stop
// - hold stop value for stop time, then off
// - count mode regulates tach period count
// - count high raises output, in range holds
// - count low lowers output
// - temperature source selects at fixed fields
package fts_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int TACH_BASE_HZ = 22_500;
  localparam int TACH_TICK_CYC = CLK_HZ / TACH_BASE_HZ;
  localparam int STEP_MS = 10;
  localparam int STEP_TICKS = STEP_MS * TACH_BASE_HZ / 1000;
  localparam logic [7:0] PWM_LAST = 8'hfe;
  // ----------------------------------------
  // Register indices
  // ----------------------------------------
  localparam logic [7:0] VAL_IDX [4] = '{8'h01, 8'h03, 8'h11, 8'h61};
  localparam logic [7:0] FRQ_IDX [4] = '{8'h00, 8'h02, 8'h10, 8'h60};
  localparam logic [7:0] IDX_SYS_TEMP = 8'h27;
  localparam logic [7:0] IDX_TSRC_A = 8'h49;
  localparam logic [7:0] IDX_TSRC_B = 8'h4a;
  localparam logic [2:0] BANK_TOP = 3'h4;
  localparam logic [2:0] K_CFG = 3'h0;
  localparam logic [2:0] K_TGT = 3'h1;
  localparam logic [2:0] K_TOL = 3'h2;
  localparam logic [2:0] K_STRT = 3'h3;
  localparam logic [2:0] K_STPV = 3'h4;
  localparam logic [2:0] K_STPT = 3'h5;
  localparam logic [2:0] K_CNT = 3'h6;
  localparam logic [2:0] K_STAT = 3'h7;
  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [7:0] VAL_RST = 8'hff;
  localparam logic [7:0] FRQ_RST = 8'h04;
  localparam logic [2:0] DIV_RST = 3'h1;
  localparam logic [7:0] TSRC_RST = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [2:0] SRC_PROC = 3'h1;
  localparam logic [2:0] SRC_AUX = 3'h2;
  typedef enum logic [1:0] {
    FTS_MANUAL = 2'h0,
    FTS_TEMP = 2'h1,
    FTS_COUNT = 2'h2
  } fts_mode_e;
  typedef struct packed {
    logic [2:0] div;
    logic stop_en;
    fts_mode_e mode;
    logic dc;
  } fts_cfg_s;
endpackage : fts_pkg

// [dv/fts_fan_ctrl_asserts.sv]
// Purpose: port checks of the fan control block
// Assumes: bound to fts_fan_ctrl
// Notes: bus has no wait states
`timescale 1ns/100ps
module fts_fan_ctrl_asserts (
  // Clock, reset and bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Fans
  input wire logic [3:0] fan_pwm,
  input wire logic [3:0][5:0] fan_dc_level,
  input wire logic [3:0] fan_warning
);
  logic tk;
  logic wr_d;
  logic [3:0] dc_on;
  assign tk = hsel & hready & htrans[1];
  assign dc_on = {|fan_dc_level[3], |fan_dc_level[2], |fan_dc_level[1], |fan_dc_level[0]};
  // Marks the data phase of a write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_d <= 1'b0;
    end else begin
      wr_d <= tk & hwrite;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_boot; $rose(hresetn); endsequence
  sequence s_no_rd; !(tk && !hwrite); endsequence
  property p_ok; hreadyout && !hresp; endproperty
  a_ok: assert property (p_ok) else $error("bus stall or error");
  property p_hi; hrdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("read data upper bits set");
  property p_idle; s_no_rd |=> hrdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
  property p_rst; s_boot |-> ##[0:2] fan_pwm == 4'hf; endproperty
  a_rst: assert property (p_rst) else $error("wave not full after reset");
  property p_rst_dc; s_boot |-> (fan_dc_level == 24'h0) [*3]; endproperty
  a_rst_dc: assert property (p_rst_dc) else $error("level driven after reset");
  property p_excl; (dc_on & fan_pwm) == 4'h0; endproperty
  a_excl: assert property (p_excl) else $error("wave and level both on");
  property p_keep; !wr_d |=> (fan_warning & $past(fan_warning)) == $past(fan_warning); endproperty
  a_keep: assert property (p_keep) else $error("warning lost without write");
  property p_wset;
    $rose(fan_warning[0]) |-> fan_pwm[0] || $past(fan_pwm[0]) || fan_dc_level[0] == 6'h3f;
  endproperty
  a_wset: assert property (p_wset) else $error("warning below full output");
endmodule : fts_fan_ctrl_asserts
bind fts_fan_ctrl fts_fan_ctrl_asserts u_asserts (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .fan_pwm(fan_pwm), .fan_dc_level(fan_dc_level), .fan_warning(fan_warning));

// [dv/fts_fan_model.sv]
// Purpose: tach pulses of the fans on the far side
// Assumes: one period shared by all four fans
// Notes: period 0 leaves the pins low, a stalled fan
`timescale 1ns/100ps
module fts_fan_model (
  // Clock and period in clocks
  input wire logic hclk,
  input wire logic [31:0] per,
  // Tach pins
  output logic [3:0] tach = 4'h0
);
  int c = 0;
  always @(posedge hclk) begin
    c <= (c + 1 >= per) ? 0 : c + 1;
    tach <= {4{per != 0 && c < 10}};
  end
endmodule : fts_fan_model

// [dv/fts_fan_ctrl_tb.sv]
// Purpose: self-checking bench of the fan control block
// Assumes: small tick divider, zero wait bus
// Notes: one task per scenario
`timescale 1ns/100ps
module fts_fan_ctrl_tb import fts_pkg::*; ();
  localparam int TK = 4;
  localparam int ST = STEP_TICKS * TK;
  localparam logic [8:0] V0 = 9'h001;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v, w;
  logic hreadyout, hresp;
  logic [7:0] t_sys = 8'h28, t_hot = 8'h50;
  logic [3:0] tach, fan_pwm, fan_warning;
  logic [3:0][5:0] fan_dc_level;
  logic [7:0] cf [6] = '{8'h1a, 8'h32, 8'h03, 8'h40, 8'h20, 8'h02};
  int per = 800, n_mismatch = 0, n_checks = 0, cyc = 0;
  fts_fan_ctrl #(.TICK_CYC(TK)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .system_temp_input(t_sys),
    .processor_temp_input(t_hot), .auxiliary_temp_input(t_hot), .tach_in(tach),
    .fan_pwm(fan_pwm), .fan_dc_level(fan_dc_level), .fan_warning(fan_warning));
  fts_fan_model u_fan (.hclk(hclk), .per(per), .tach(tach));
  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      final_report;
    end
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask : wt
  // One single transfer; read data lands in v
  task automatic bus(input logic [8:0] i, input logic we, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {21'h0, i, 2'h0};
    htrans <= 2'h2;
    hwrite <= we;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask : bus
  task automatic rc(input logic [8:0] i, input logic [31:0] e, input string n);
    bus(i, 1'b0, 8'h00);
    chk(v, e, n);
  endtask : rc
  task automatic near(input logic [31:0] e);
    bus(9'h086, 1'b0, 8'h00);
    chk({31'h0, v + 1 >= e && v <= e + 1}, 32'h1, "count");
  endtask : near
  task automatic duty(input int f, input logic [7:0] d, input int s);
    int h;
    h = 0;
    bus({1'b0, VAL_IDX[f]}, 1'b1, d);
    wt(255 * s);
    repeat (255 * s) begin
      @(posedge hclk);
      h += (fan_pwm[f] === 1'b1);
    end
    chk(h, 32'(d * s), "high cycles");
  endtask : duty
  task automatic t_reset;
    for (int f = 0; f < 4; f++) begin
      rc({1'b0, VAL_IDX[f]}, {24'h0, VAL_RST}, "value");
      rc({1'b0, FRQ_IDX[f]}, {24'h0, FRQ_RST}, "freq");
      rc(9'(128 + f * 8), 32'h10, "cfg");
      rc(9'(134 + f * 8), {24'h0, CNT_MAX}, "count");
    end
    chk({28'h0, fan_pwm}, 32'hf, "wave");
    rc(9'h100, 32'h0, "unmapped");
    rc(9'h049, {24'h0, TSRC_RST}, "source");
    bus(9'h027, 1'b1, 8'h55);
    rc(9'h027, {24'h0, t_sys}, "temp");
    bus(9'h049, 1'b1, 8'h21);
    rc(9'h049, 32'h21, "source a");
    bus(9'h04a, 1'b1, 8'he0);
    rc(9'h04a, 32'he0, "source b");
    $display("test reset done");
  endtask : t_reset
  task automatic t_out;
    bus({1'b0, FRQ_IDX[0]}, 1'b1, 8'h00);
    bus({1'b0, FRQ_IDX[1]}, 1'b1, 8'h01);
    duty(0, 8'h00, 1);
    duty(0, 8'h80, 1);
    duty(0, 8'hff, 1);
    duty(1, 8'h40, 2);
    bus(9'h090, 1'b1, 8'h11);
    bus({1'b0, VAL_IDX[2]}, 1'b1, 8'ha7);
    wt(4);
    chk({26'h0, fan_dc_level[2]}, 32'h29, "level");
    chk({31'h0, fan_pwm[2]}, 32'h0, "wave in dc");
    $display("test outputs done");
  endtask : t_out
  task automatic t_tach;
    wt(2000);
    near(100);
    bus(9'h080, 1'b1, 8'h00);
    wt(2000);
    near(200);
    bus(9'h080, 1'b1, 8'h70);
    wt(2000);
    near(2);
    bus(9'h080, 1'b1, 8'h00);
    per <= 0;
    wt(2500);
    rc(9'h086, 32'hff, "stall");
    per <= 800;
    bus(9'h080, 1'b1, 8'h10);
    $display("test tach done");
  endtask : t_tach
  task automatic t_temp;
    int k;
    k = 0;
    for (int j = 5; j >= 0; j--) bus(9'(128 + j), 1'b1, cf[j]);
    bus(V0, 1'b1, 8'h00);
    wt(2 * ST);
    rc(V0, 32'h0, "off");
    t_sys <= 8'h32;
    wt(2 * ST);
    rc(V0, 32'h40, "start");
    t_sys <= 8'h3c;
    wt(2 * ST);
    bus(V0, 1'b0, 8'h00);
    chk({31'h0, v > 32'h40}, 32'h1, "up");
    bus(V0, 1'b1, 8'hff);
    wt(2 * ST);
    rc(9'h087, 32'h1, "status");
    chk({28'h0, fan_warning}, 32'h1, "warning");
    t_sys <= 8'h32;
    bus(9'h087, 1'b1, 8'h01);
    rc(9'h087, 32'h0, "cleared");
    bus(V0, 1'b1, 8'h22);
    t_sys <= 8'h28;
    do begin
      wt(50);
      bus(V0, 1'b0, 8'h00);
      k++;
    end while (v !== 32'h20 && k < 100);
    chk(v, 32'h20, "stop");
    wt(ST / 2);
    rc(V0, 32'h20, "stop hold");
    wt(3 * ST);
    rc(V0, 32'h0, "stopped");
    $display("test temp done");
  endtask : t_temp
  task automatic t_cnt;
    bus(9'h081, 1'b1, 8'h50);
    bus(9'h082, 1'b1, 8'h05);
    bus(V0, 1'b1, 8'h40);
    bus(9'h080, 1'b1, 8'h14);
    wt(2 * ST);
    bus(V0, 1'b0, 8'h00);
    chk({31'h0, v > 32'h40}, 32'h1, "count up");
    bus(9'h081, 1'b1, 8'h78);
    bus(V0, 1'b0, 8'h00);
    w = v;
    wt(2 * ST);
    bus(V0, 1'b0, 8'h00);
    chk({31'h0, v < w}, 32'h1, "count down");
    bus(9'h081, 1'b1, 8'h64);
    bus(V0, 1'b0, 8'h00);
    w = v;
    wt(2 * ST);
    rc(V0, w, "count hold");
    $display("test count done");
  endtask : t_cnt
  // Fans 1 and 2 follow the hot processor and auxiliary inputs, fan 3 the cool system one
  task automatic t_src;
    for (int f = 1; f < 4; f++) begin
      bus(9'(129 + f * 8), 1'b1, 8'h30);
      bus({1'b0, VAL_IDX[f]}, 1'b1, 8'h40);
      bus(9'(128 + f * 8), 1'b1, 8'h12);
    end
    wt(2 * ST);
    for (int f = 1; f < 4; f++) begin
      bus({1'b0, VAL_IDX[f]}, 1'b0, 8'h00);
      chk({31'h0, (v > 32'h40) == (f < 3)}, 32'h1, "source");
    end
    $display("test source done");
  endtask : t_src
  initial begin
    wt(12);
    hresetn <= 1'b1;
    t_reset;
    t_out;
    t_tach;
    t_temp;
    t_cnt;
    t_src;
    final_report;
  end
endmodule : fts_fan_ctrl_tb
